// >>> rtl/lic_pkg.sv
// constants for the led intensity and main configuration block
// assumes a 100 MHz system clock and a simple strobe register port
package lic_pkg;

   // ****************************************
   // register map
   // ****************************************
   localparam logic [15:0] MAIN_CONFIGURATION_ADDR = 16'h0000;
   localparam logic [15:0] LED_CONFIGURATION_ADDR  = 16'h0001;
   localparam logic [15:0] LED_INITIAL_DUTY_ADDR   = 16'h0002;
   localparam logic [15:0] LED_DUTY_ACTUAL_ADDR    = 16'h0010;
   localparam logic [15:0] LOOP_STATUS_ADDR        = 16'h0011;
   localparam logic [15:0] MAIN_STATUS_ADDR        = 16'h0012;

   localparam logic [7:0] MAIN_CONFIGURATION_RST = 8'h00;
   localparam logic [7:0] LED_CONFIGURATION_RST  = 8'h00;
   localparam logic [7:0] LED_INITIAL_DUTY_RST   = 8'h00;

   // ****************************************
   // field positions
   // ****************************************
   localparam int MAIN_RANGE_LSB    = 0;
   localparam int MAIN_NOISE_BIT    = 2;
   localparam int MAIN_LINEDRV_BIT  = 3;
   localparam int MAIN_IRQPP_BIT    = 4;
   localparam int MAIN_LINKOFF_BIT  = 5;
   localparam int LED_EN_BIT        = 0;
   localparam int LED_POL_BIT       = 1;
   localparam int LED_ODRAIN_BIT    = 2;
   localparam int LED_AUTO_BIT      = 3;
   localparam int LED_RATE_LSB      = 4;
   localparam int LED_MARGIN_LSB    = 6;

   localparam logic [1:0] RANGE_LOW      = 2'h0;
   localparam logic [1:0] RANGE_LOW_LOSS = 2'h1;
   localparam logic [1:0] RANGE_HIGH     = 2'h2;
   localparam logic [1:0] RANGE_RESERVED = 2'h3;

   localparam logic [7:0] MARGIN_STEP = 8'h08;

   // ****************************************
   // timing
   // ****************************************
   localparam int CLK_MHZ         = 100;
   localparam int LAT_LIGHT_NS    = 1500;
   localparam int LAT_HEAVY_NS    = 1900;
   localparam int LAT_LIGHT_CYC   = LAT_LIGHT_NS * CLK_MHZ / 1000;
   localparam int LAT_HEAVY_CYC   = LAT_HEAVY_NS * CLK_MHZ / 1000;
   localparam int DSM_BASE_DIV    = 32;
   localparam int CTRL_PERIOD_CYC = 4096;

   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_LOAD  = 2'b01,
      ST_RUN   = 2'b11
   } lic_state_t;

endpackage

// >>> rtl/lic_dsm.sv
// first-order delta-sigma modulator for the led duty
// assumes a single clock; step is a one-cycle tick at the modulator rate
`timescale 1ns/1ps
`default_nettype none
module lic_dsm #(
   parameter int WIDTH = 8
) (
   // clock and reset
   input  wire logic             mclk,
   input  wire logic             resetn,
   // modulator control
   input  wire logic             step,
   input  wire logic [WIDTH-1:0] duty,
   // bit stream
   output logic                  bitOut
);

   logic [WIDTH-1:0] accum;
   logic [WIDTH:0]   sum;

   assign sum = {1'b0, accum} + {1'b0, duty};

   // carry of the accumulator is the density-matched bit
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         accum  <= '0;
         bitOut <= 1'b0;
      end else if (step) begin
         accum  <= sum[WIDTH-1:0];
         bitOut <= sum[WIDTH];
      end
   end

endmodule
`default_nettype wire

// >>> rtl/lic_top.sv
// led intensity generator with main configuration register
// assumes strobe register port, amplitude inputs synchronous to mclk
// Function
// - input range field: low, low with loss detect, high with loss detect; 3 reserved
// - noise bit picks light filter 1.5 us or heavy 1.9 us latency
// - bit 3 enables differential line driver on incremental outputs
// - bit 4 selects interrupt output push-pull, else open-drain
// - bit 5 makes the device ignore config link activation
// - led configuration bit 0 enables the led pin
// - disabled pin: low or high by polarity, hi-z when open-drain
// - polarity bit inverts the pwm high time while enabled
// - led configuration bit 2 selects open-drain drive when enabled
// - auto bit enables regulation; otherwise starting duty is held
// - bits 5:4 choose modulator rate 3.125 to 25 MHz
// - bits 7:6 choose hysteresis margin 8, 16, 24 or 32
// - raise duty below low limit plus margin, lower above high minus margin
// - starting duty loaded from nonvolatile memory at startup
// - calibration drives the led at starting duty regardless of configuration
// - actual duty register holds live duty; a write takes effect at once, but with led enabled and auto clear the starting duty replaces it next cycle
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module lic_top
   import lic_pkg::*;
#(
   parameter int CTRL_PERIOD = CTRL_PERIOD_CYC
) (
   // clock and reset
   input  wire logic        mclk,
   input  wire logic        resetn,
   // register port
   input  wire logic [15:0] regAddr,
   input  wire logic [7:0]  regWdata,
   input  wire logic        regWrite,
   input  wire logic        regRead,
   output logic      [7:0]  regRdata,
   // nonvolatile startup load
   input  wire logic        nvLoad,
   input  wire logic [7:0]  nvMainConfiguration,
   input  wire logic [7:0]  nvLedConfiguration,
   input  wire logic [7:0]  nvLedInitialDuty,
   // calibration
   input  wire logic        calibration_request_n,
   input  wire logic        calibCommandActive,
   // amplitude loop inputs
   input  wire logic [7:0]  sensor_amplitude,
   input  wire logic [7:0]  amplitude_lower_limit,
   input  wire logic [7:0]  amplitude_upper_limit,
   input  wire logic        amplitudeValid,
   // link activation and interrupt source
   input  wire logic        linkActivateSeen,
   input  wire logic        irqAssert,
   // analog and driver controls
   output logic      [1:0]  inputRange,
   output logic             lossDetectEnable,
   output logic             highRangeAtten,
   output logic             heavyFilter,
   output logic      [7:0]  filterLatencyCycles,
   output logic             lineDriverEnable,
   output logic             linkActivate,
   // interrupt pin
   output logic             interrupt_request_out_n,
   output logic             irqOe,
   // led pin
   output logic             ledOut,
   output logic             ledOe
);

   // ****************************************
   // registers
   // ****************************************
   logic [7:0]  mainConfiguration;
   logic [7:0]  ledConfiguration;
   logic [7:0]  ledInitialDuty;
   logic [7:0]  led_duty_actual;
   logic        started;
   logic [1:0]  loopDir;
   lic_state_t  state;

   logic        ledEn;
   logic        ledPol;
   logic        ledOdrain;
   logic        ledAuto;
   logic [1:0]  ledRate;
   logic [7:0]  margin;
   logic        calibrating;
   logic        dsmBit;
   logic        dsmStep;
   logic [15:0] ctrlCount;
   logic        ctrlTick;
   logic [8:0]  lowThresh;
   logic [8:0]  highThresh;
   logic        wantUp;
   logic        wantDown;
   logic [7:0]  driveDuty;
   logic        pwmLevel;

   assign ledEn     = ledConfiguration[LED_EN_BIT];
   assign ledPol    = ledConfiguration[LED_POL_BIT];
   assign ledOdrain = ledConfiguration[LED_ODRAIN_BIT];
   assign ledAuto   = ledConfiguration[LED_AUTO_BIT];
   assign ledRate   = ledConfiguration[LED_RATE_LSB +: 2];
   // margin is (code + 1) * 8
   assign margin    = MARGIN_STEP * ({6'h00, ledConfiguration[LED_MARGIN_LSB +: 2]} + 8'h01);
   assign calibrating = !calibration_request_n || calibCommandActive;

   // ****************************************
   // configuration writes and startup load
   // ****************************************
   // the startup load beats a software write landing in the same cycle
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         mainConfiguration <= MAIN_CONFIGURATION_RST;
      end else if (nvLoad) begin
         mainConfiguration <= nvMainConfiguration;
      end else if (regWrite && regAddr == MAIN_CONFIGURATION_ADDR) begin
         mainConfiguration <= regWdata;
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         ledConfiguration <= LED_CONFIGURATION_RST;
      end else if (nvLoad) begin
         ledConfiguration <= nvLedConfiguration;
      end else if (regWrite && regAddr == LED_CONFIGURATION_ADDR) begin
         ledConfiguration <= regWdata;
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         ledInitialDuty <= LED_INITIAL_DUTY_RST;
      end else if (nvLoad) begin
         ledInitialDuty <= nvLedInitialDuty;
      end else if (regWrite && regAddr == LED_INITIAL_DUTY_ADDR) begin
         ledInitialDuty <= regWdata;
      end
   end

   // ****************************************
   // main configuration decode
   // ****************************************
   logic [1:0]  rangeCode;
   assign rangeCode = mainConfiguration[MAIN_RANGE_LSB +: 2];

   // registered decode keeps the range, filter and line driver controls free of glitches; linkActivate is not registered
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         inputRange          <= RANGE_LOW;
         lossDetectEnable    <= 1'b0;
         highRangeAtten      <= 1'b0;
         heavyFilter         <= 1'b0;
         filterLatencyCycles <= 8'(LAT_LIGHT_CYC);
         lineDriverEnable    <= 1'b0;
      end else begin
         inputRange          <= rangeCode;
         // reserved code 3 acts as plain low range
         lossDetectEnable    <= (rangeCode == RANGE_LOW_LOSS) ||
                                (rangeCode == RANGE_HIGH);
         highRangeAtten      <= (rangeCode == RANGE_HIGH);
         heavyFilter         <= mainConfiguration[MAIN_NOISE_BIT];
         filterLatencyCycles <= mainConfiguration[MAIN_NOISE_BIT] ? 8'(LAT_HEAVY_CYC) :
                                8'(LAT_LIGHT_CYC);
         lineDriverEnable    <= mainConfiguration[MAIN_LINEDRV_BIT];
      end
   end
   // software owns keeping the link off in spi-only modes
   assign linkActivate     = linkActivateSeen && !mainConfiguration[MAIN_LINKOFF_BIT];

   // open-drain only ever pulls low, so the wire-or stays safe
   always_comb begin
      interrupt_request_out_n = !irqAssert;
      if (mainConfiguration[MAIN_IRQPP_BIT]) begin
         irqOe = 1'b1;
      end else begin
         irqOe = irqAssert;
      end
   end

   // ****************************************
   // duty state machine
   // ****************************************
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         state   <= ST_IDLE;
         started <= 1'b0;
      end else begin
         case (state)
            ST_IDLE: begin
               if (nvLoad) begin
                  state <= ST_LOAD;
               end
            end
            ST_LOAD: begin
               state   <= ST_RUN;
               started <= 1'b1;
            end
            ST_RUN: begin
               if (nvLoad) begin
                  state <= ST_LOAD;
               end
            end
            default: state <= ST_IDLE;
         endcase
      end
   end

   // ****************************************
   // control loop pacing and thresholds
   // ****************************************
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         ctrlCount <= '0;
      end else if (ctrlCount >= 16'(CTRL_PERIOD - 1)) begin
         ctrlCount <= '0;
      end else begin
         ctrlCount <= ctrlCount + 16'h0001;
      end
   end
   assign ctrlTick = (ctrlCount >= 16'(CTRL_PERIOD - 1));

   assign lowThresh  = {1'b0, amplitude_lower_limit} + {1'b0, margin};
   assign highThresh = {1'b0, amplitude_upper_limit} - {1'b0, margin};
   assign wantUp     = ({1'b0, sensor_amplitude} < lowThresh);
   // guard a margin bigger than the high limit from wrapping
   assign wantDown   = (amplitude_upper_limit >= margin) &&
                       ({1'b0, sensor_amplitude} > highThresh);

   // ****************************************
   // live duty
   // ****************************************
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         led_duty_actual <= 8'h00;
      end else if (regWrite && regAddr == LED_DUTY_ACTUAL_ADDR) begin
         led_duty_actual <= regWdata;
      end else if (state == ST_LOAD && ledEn) begin
         led_duty_actual <= ledInitialDuty;
      end else if (ledEn && !ledAuto) begin
         led_duty_actual <= ledInitialDuty;
      end else if (ledEn && ledAuto && ctrlTick && amplitudeValid) begin
         if (wantUp && led_duty_actual != 8'hff) begin
            led_duty_actual <= led_duty_actual + 8'h01;
         end else if (wantDown && !wantUp && led_duty_actual != 8'h00) begin
            led_duty_actual <= led_duty_actual - 8'h01;
         end
      end
   end

   // last loop decision, kept for the status read back
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         loopDir <= 2'h0;
      end else if (ledEn && ledAuto && ctrlTick && amplitudeValid) begin
         loopDir <= {wantUp, wantDown};
      end
   end

   // ****************************************
   // modulator rate
   // ****************************************
   // rate = 100 MHz / (32 >> code): 3.125, 6.25, 12.5, 25 MHz
   // one free-running divider serves all rates, so a rate change never stalls the stream
   logic [4:0] rateFull;
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         rateFull <= 5'h00;
      end else begin
         rateFull <= rateFull + 5'h01;
      end
   end

   always_comb begin
      case (ledRate)
         2'h0:    dsmStep = (rateFull == 5'h1f);
         2'h1:    dsmStep = (rateFull[3:0] == 4'hf);
         2'h2:    dsmStep = (rateFull[2:0] == 3'h7);
         2'h3:    dsmStep = (rateFull[1:0] == 2'h3);
         default: dsmStep = 1'b0;
      endcase
   end

   // calibration overrides the live duty with the starting duty
   assign driveDuty = calibrating ? ledInitialDuty : led_duty_actual;

   lic_dsm #(
      .WIDTH (8)
   ) u_dsm (
      .mclk   (mclk),
      .resetn (resetn),
      .step   (dsmStep),
      .duty   (driveDuty),
      .bitOut (dsmBit)
   );

   // ****************************************
   // led pin drive
   // ****************************************
   always_comb begin
      pwmLevel = dsmBit;
      ledOut   = 1'b0;
      ledOe    = 1'b0;
      if (calibrating) begin
         // configuration bits are ignored, push-pull positive
         ledOut = pwmLevel;
         ledOe  = 1'b1;
      end else if (ledEn && started) begin
         pwmLevel = dsmBit ^ ledPol;
         if (ledOdrain) begin
            ledOut = 1'b0;
            ledOe  = !pwmLevel;
         end else begin
            ledOut = pwmLevel;
            ledOe  = 1'b1;
         end
      end else begin
         ledOut = ledPol && !ledOdrain;
         ledOe  = !ledOdrain;
      end
   end

   // ****************************************
   // read back
   // ****************************************
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         regRdata <= 8'h00;
      end else if (regRead) begin
         case (regAddr)
            MAIN_CONFIGURATION_ADDR: regRdata <= mainConfiguration;
            LED_CONFIGURATION_ADDR:  regRdata <= ledConfiguration;
            LED_INITIAL_DUTY_ADDR:   regRdata <= ledInitialDuty;
            LED_DUTY_ACTUAL_ADDR:    regRdata <= led_duty_actual;
            LOOP_STATUS_ADDR:        regRdata <= {4'h0, calibrating, started, loopDir};
            MAIN_STATUS_ADDR:        regRdata <= {5'h00, linkActivate, lossDetectEnable,
                                                  highRangeAtten};
            default:                 regRdata <= 8'h00;
         endcase
      end else begin
         regRdata <= 8'h00;
      end
   end

endmodule
`default_nettype wire

// >>> sim/lic_sva.sv
// port checker for the led intensity and main configuration block
// assumes it is bound onto lic_top and that everything runs on mclk
`timescale 1ns/1ps
`default_nettype none
module lic_sva
   import lic_pkg::*;
#(
   parameter int CTRL_PERIOD = CTRL_PERIOD_CYC
) (
   // clock and reset
   input wire logic       mclk,
   input wire logic       resetn,
   // register port
   input wire logic       regRead,
   input wire logic [7:0] regRdata,
   // control inputs
   input wire logic       calibration_request_n,
   input wire logic       calibCommandActive,
   input wire logic       linkActivateSeen,
   input wire logic       irqAssert,
   // outputs
   input wire logic [1:0] inputRange,
   input wire logic       lossDetectEnable,
   input wire logic       highRangeAtten,
   input wire logic       heavyFilter,
   input wire logic [7:0] filterLatencyCycles,
   input wire logic       linkActivate,
   input wire logic       interrupt_request_out_n,
   input wire logic       irqOe,
   input wire logic       ledOut,
   input wire logic       ledOe
);
   // ****************************************
   // assertions
   // ****************************************
   default clocking @(posedge mclk);
   endclocking
   default disable iff (!resetn);

   a_rdata_idle: assert property (!$past(regRead) |-> regRdata == 8'h00)
      else $error("read data not zero outside read answer");
   a_range_loss: assert property (lossDetectEnable == (inputRange inside {2'h1, 2'h2}))
      else $error("loss detect does not follow range");
   a_range_high: assert property (highRangeAtten == (inputRange == RANGE_HIGH))
      else $error("attenuation does not follow range");
   a_latency_map: assert property (filterLatencyCycles ==
      (heavyFilter ? 8'(LAT_HEAVY_CYC) : 8'(LAT_LIGHT_CYC)))
      else $error("latency does not follow filter");
   a_irq_level: assert property (irqAssert |-> !interrupt_request_out_n && irqOe)
      else $error("interrupt not driven active");
   a_irq_idle: assert property (!irqAssert |-> interrupt_request_out_n)
      else $error("interrupt active without source");
   a_link_gate: assert property (!linkActivateSeen |-> !linkActivate)
      else $error("link activated without sequence");
   a_release_low: assert property (!ledOe |-> !ledOut)
      else $error("led driven high while released");
   a_calib_drive: assert property ((!calibration_request_n || calibCommandActive)[*3]
      |-> ledOe)
      else $error("led not push-pull in calibration");

   c_heavy: cover property (heavyFilter);
   c_link: cover property (linkActivate);
   c_calib: cover property (!calibration_request_n && ledOut);
endmodule
bind lic_top lic_sva #(.CTRL_PERIOD(CTRL_PERIOD)) u_sva (.*);
`default_nettype wire

// >>> sim/lic_led_sensor.sv
// led and photodiode model: lit time per 256-cycle window gives the amplitude
// assumes the pin is lit while driven high
`timescale 1ns/1ps
`default_nettype none
module lic_led_sensor (
   // clock and reset
   input  wire logic       mclk,
   input  wire logic       resetn,
   // led pin
   input  wire logic       ledOut,
   input  wire logic       ledOe,
   // photodiode side
   output logic      [7:0] amplitude,
   output logic            ampValid
);
   logic [7:0] phase;
   logic [8:0] litCount;
   // weak coupling: full light reaches only half scale, so a loop can always climb
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         phase <= 8'h00;
         litCount <= 9'h000;
         amplitude <= 8'h00;
         ampValid <= 1'b0;
      end else begin
         phase <= phase + 8'h01;
         if (phase == 8'hff) begin
            amplitude <= litCount[8:1];
            ampValid <= 1'b1;
            litCount <= 9'(ledOe & ledOut);
         end else begin
            litCount <= litCount + 9'(ledOe & ledOut);
         end
      end
   end
endmodule
`default_nettype wire

// >>> sim/led_intensity_and_main_config_tb.sv
// testbench: register tasks, led pin measurement and loop steps
// assumes lic_top with a short control period and the led sensor model
`timescale 1ns/1ps
`default_nettype none
module led_intensity_and_main_config_tb
   import lic_pkg::*;
;
   localparam int PER = 16;
   logic mclk = 1'b0, resetn = 1'b0, regWrite = 1'b0, regRead = 1'b0, nvLoad = 1'b0;
   logic [15:0] regAddr = 16'h0000;
   logic [7:0] regWdata = 8'h00, regRdata, d0, d1, v;
   logic [7:0] nvMainConfiguration = 8'h00, nvLedConfiguration = 8'h31;
   logic [7:0] nvLedInitialDuty = 8'h5a, sensor_amplitude;
   logic [7:0] amplitude_lower_limit = 8'hc0, amplitude_upper_limit = 8'hff;
   logic calibration_request_n = 1'b1, calibCommandActive = 1'b0, amplitudeValid;
   logic linkActivateSeen = 1'b1, irqAssert = 1'b0, lossDetectEnable, highRangeAtten;
   logic heavyFilter, lineDriverEnable, linkActivate, interrupt_request_out_n;
   logic irqOe, ledOut, ledOe;
   logic [1:0] inputRange;
   logic [7:0] filterLatencyCycles;
   int failures = 0, samples_checked = 0;

   lic_top #(.CTRL_PERIOD(PER)) u_dut (.*);
   lic_led_sensor u_led (.mclk(mclk), .resetn(resetn), .ledOut(ledOut), .ledOe(ledOe),
      .amplitude(sensor_amplitude), .ampValid(amplitudeValid));

   always #5 mclk = ~mclk;

   // ****************************************
   // tasks
   // ****************************************
   task automatic conclude();
      $display("checks %0d mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      samples_checked++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge mclk);
      regWrite <= 1'b1;
      regAddr <= a;
      regWdata <= d;
      @(posedge mclk);
      regWrite <= 1'b0;
   endtask
   task automatic rd(input logic [15:0] a, output logic [7:0] d);
      @(posedge mclk);
      regRead <= 1'b1;
      regAddr <= a;
      @(posedge mclk);
      regRead <= 1'b0;
      #1 d = regRdata;
   endtask
   task automatic rdchk(input logic [15:0] a, input logic [7:0] e, input string what);
      logic [7:0] d;
      rd(a, d);
      chk(what, {8'h00, e}, {8'h00, d});
   endtask
   // window is whole modulator periods, so the high count is exact from any phase
   task automatic measure(input string what, input bit odr, input int div, input int e);
      int n = 0;
      repeat (40) @(posedge mclk);
      repeat (256 * div) begin
         @(posedge mclk);
         #1 n += odr ? int'(!ledOe) : int'(ledOut === 1'b1);
      end
      chk(what, 16'(e), 16'(n));
   endtask
   // two duty reads one control period apart see exactly one update
   task automatic loopStep(input logic [7:0] delta, input string what);
      rd(LED_DUTY_ACTUAL_ADDR, d0);
      repeat (PER - 2) @(posedge mclk);
      rd(LED_DUTY_ACTUAL_ADDR, d1);
      chk(what, {8'h00, 8'(d0 + delta)}, {8'h00, d1});
   endtask

   // ****************************************
   // tests
   // ****************************************
   initial begin
      repeat (60000) @(posedge mclk);
      failures++;
      conclude();
   end

   initial begin
      repeat (16) @(posedge mclk);
      resetn <= 1'b1;
      rdchk(MAIN_CONFIGURATION_ADDR, MAIN_CONFIGURATION_RST, "mainCfg");
      rdchk(LED_CONFIGURATION_ADDR, LED_CONFIGURATION_RST, "ledCfg");
      rdchk(LED_INITIAL_DUTY_ADDR, LED_INITIAL_DUTY_RST, "initDuty");
      wr(16'h0003, 8'hff);
      rdchk(16'h0003, 8'h00, "unmapped");
      @(posedge mclk);
      nvLoad <= 1'b1;
      @(posedge mclk);
      nvLoad <= 1'b0;
      repeat (3) @(posedge mclk);
      rdchk(LED_INITIAL_DUTY_ADDR, 8'h5a, "initDuty");
      rdchk(LED_DUTY_ACTUAL_ADDR, 8'h5a, "startDuty");
      $display("test registers and startup done");
      for (int i = 0; i < 8; i++) begin
         v = (i < 4) ? 8'(i) : 8'h01 << (i - 2);
         wr(MAIN_CONFIGURATION_ADDR, v);
         @(posedge mclk);
         #1 chk("mainOutputs", {v[1:0], (v[1:0] inside {2'h1, 2'h2}), (v[1:0] == 2'h2), v[2],
            v[3], v[4], !v[5], (v[2] ? 8'(LAT_HEAVY_CYC) : 8'(LAT_LIGHT_CYC))}, {inputRange,
            lossDetectEnable, highRangeAtten, heavyFilter, lineDriverEnable, irqOe,
            linkActivate, filterLatencyCycles});
         rdchk(MAIN_CONFIGURATION_ADDR, v, "mainCfg");
         d0 = {5'h00, !v[5], (v[1:0] inside {2'h1, 2'h2}), (v[1:0] == 2'h2)};
         rdchk(MAIN_STATUS_ADDR, d0, "mainStatus");
      end
      @(posedge mclk);
      irqAssert <= 1'b1;
      @(posedge mclk);
      #1 chk("irqPin", 16'h0001, {14'h0, interrupt_request_out_n, irqOe});
      @(posedge mclk);
      irqAssert <= 1'b0;
      $display("test main configuration done");
      for (int i = 0; i < 4; i++) begin
         wr(LED_CONFIGURATION_ADDR, 8'(i << 1));
         repeat (2) @(posedge mclk);
         #1 chk("ledIdle", {14'h0, !i[1], i[0] & !i[1]}, {14'h0, ledOe, ledOut});
      end
      wr(LED_INITIAL_DUTY_ADDR, 8'h5a);
      for (int r = 0; r < 4; r++) begin
         wr(LED_CONFIGURATION_ADDR, {2'h0, 2'(r), 1'b0, 2'(r), 1'b1});
         wr(LED_DUTY_ACTUAL_ADDR, 8'h11);
         rdchk(LED_DUTY_ACTUAL_ADDR, 8'h5a, "heldDuty");
         measure("highTime", r[1], DSM_BASE_DIV >> r,
            (r[0] ? 256 - 'h5a : 'h5a) * (DSM_BASE_DIV >> r));
      end
      $display("test led pin done");
      wr(LED_CONFIGURATION_ADDR, 8'h39);
      wr(LED_DUTY_ACTUAL_ADDR, 8'h30);
      loopStep(8'h01, "dutyUp");
      wr(LED_DUTY_ACTUAL_ADDR, 8'hff);
      loopStep(8'h00, "dutySat");
      @(posedge mclk);
      amplitude_lower_limit <= 8'h00;
      amplitude_upper_limit <= 8'h48;
      wr(LED_CONFIGURATION_ADDR, 8'hf9);
      wr(LED_DUTY_ACTUAL_ADDR, 8'ha0);
      repeat (600) @(posedge mclk);
      loopStep(8'hff, "dutyDown");
      rdchk(LOOP_STATUS_ADDR, 8'h05, "loopStatus");
      $display("test control loop done");
      wr(LED_CONFIGURATION_ADDR, 8'h06);
      calibration_request_n <= 1'b0;
      measure("calibHigh", 1'b0, DSM_BASE_DIV, 'h5a * DSM_BASE_DIV);
      @(posedge mclk);
      calibration_request_n <= 1'b1;
      calibCommandActive <= 1'b1;
      repeat (8) @(posedge mclk);
      #1 chk("calibDrive", 16'h0001, {15'h0, ledOe});
      @(posedge mclk);
      calibCommandActive <= 1'b0;
      $display("test calibration done");
      conclude();
   end
endmodule
`default_nettype wire
